// [verilog/pt8_pkg.sv]
// package of offsets, fields and reset values for the 8-bit period timer
package pt8_pkg;
  localparam logic [7:0] PT8_FLAGS_IDX    = 8'h0C;
  localparam logic [7:0] PT8_COUNT_IDX    = 8'h11;
  localparam logic [7:0] PT8_CONTROL_IDX  = 8'h12;
  localparam logic [7:0] PT8_ENABLES_IDX  = 8'h8C;
  localparam logic [7:0] PT8_LIMIT_IDX    = 8'h92;
  localparam int         PT8_ADDR_W       = 12;
  localparam int         PT8_MATCH_BIT    = 1;
  localparam int         PT8_PRE_LSB      = 0;
  localparam int         PT8_ON_BIT       = 2;
  localparam int         PT8_POST_LSB     = 3;
  localparam logic [7:0] PT8_COUNT_RST    = 8'h00;
  localparam logic [7:0] PT8_LIMIT_RST    = 8'hFF;
  localparam logic [6:0] PT8_CONTROL_RST  = 7'h00;
  localparam logic [7:0] PT8_FLAGS_RST    = 8'h00;
  localparam logic [7:0] PT8_ENABLES_RST  = 8'h00;
  localparam logic [3:0] PT8_PRE_DIV1_END = 4'h0;
  localparam logic [3:0] PT8_PRE_DIV4_END = 4'h3;
  localparam logic [3:0] PT8_PRE_DIV16_END = 4'hF;
  localparam logic [1:0] PT8_QDIV_END     = 2'h3;
  function automatic logic [PT8_ADDR_W-1:0] pt8_byte_addr(input logic [7:0] idx);
    pt8_byte_addr = {2'b00, idx, 2'b00};
  endfunction : pt8_byte_addr
endpackage : pt8_pkg

// [verilog/pt8_scaler.sv]
// small clearable divider: pulses when its count reaches a programmable end
`timescale 1ns/1ns
module pt8_scaler #(
  parameter int W = 4
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         clr,
  input  wire logic         tick,
  input  wire logic [W-1:0] last,
  output logic              pulse
);
  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  wire          at_end = (cnt_ff >= last);
  assign pulse   = tick & at_end & ~clr;
  assign nxt_cnt = clr ? '0 : (tick ? (at_end ? '0 : cnt_ff + 1'b1) : cnt_ff);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end
endmodule : pt8_scaler

// [verilog/pt8_timer.sv]
// 8-bit period timer with prescaler, postscaler and an APB register slave
// Function
// - 8-bit up-counter fed through a prescaler; match goes through a postscaler.
// - count is software read/write and zero after every reset.
// - counter ticks at instruction clock divided by 1, 4 or 16.
// - count runs from zero to period limit, then wraps to zero with a match.
// - period limit is read/write and resets to all ones.
// - postscaler divides matches by 1 to 16 and sets flag bit 1.
// - counting happens only while count enable (control bit 2) is set.
// - count write, control write or reset clears both scaler counters.
// - a control write leaves the count unchanged.
// - period match is exported as the PWM time base.
// - un-postscaled match is given to the serial port for its shift clock.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ns
module pt8_timer
  import pt8_pkg::*;
(
  input  wire logic                       pclk,
  input  wire logic                       presetn,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [pt8_pkg::PT8_ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic                            pwm_period_match,
  output logic                            serial_shift_tick,
  output logic                            period_match_irq
);
  logic [1:0] qdiv_ff;
  logic [7:0] count_ff;
  logic [7:0] limit_ff;
  logic [6:0] control_ff;
  logic       flag_ff;
  logic       irq_en_ff;
  logic [31:0] rdata_ff;
  logic       slverr_ff;
  logic       pwm_ff;
  logic       ssp_ff;
  logic       irq_ff;
  logic       ready_ff;
  logic [1:0] nxt_qdiv;
  logic [7:0] nxt_count;
  logic       nxt_flag;
  logic [31:0] nxt_rdata;

  function automatic logic hit(input logic [PT8_ADDR_W-1:0] a, input logic [7:0] idx);
    hit = (a == pt8_byte_addr(idx));
  endfunction : hit

  // apb decode; the slave answers in the access phase with no wait state
  wire        acc       = psel & penable;
  wire        wr        = acc & pwrite;
  wire        hit_flags = hit(paddr, PT8_FLAGS_IDX);
  wire        hit_en    = hit(paddr, PT8_ENABLES_IDX);
  wire        hit_count = hit(paddr, PT8_COUNT_IDX);
  wire        hit_ctrl  = hit(paddr, PT8_CONTROL_IDX);
  wire        hit_limit = hit(paddr, PT8_LIMIT_IDX);
  wire        mapped    = hit_flags | hit_en | hit_count | hit_ctrl | hit_limit;
  wire        wr_count  = wr & hit_count;
  wire        wr_ctrl   = wr & hit_ctrl;
  wire        wr_flags  = wr & hit_flags;

  wire        count_on  = control_ff[PT8_ON_BIT];
  wire [1:0]  pre_sel   = control_ff[PT8_PRE_LSB +: 2];
  wire [3:0]  post_sel  = control_ff[PT8_POST_LSB +: 4];
  // scalers restart on any count or control write so the next period is whole
  wire        scl_clr   = wr_count | wr_ctrl;

  // instruction clock: one cycle in four of pclk stands for one instruction cycle
  wire        instr_tick = count_on & (qdiv_ff == PT8_QDIV_END);
  assign nxt_qdiv = (scl_clr | ~count_on) ? 2'b00 : qdiv_ff + 2'b01;

  // prescale end count: /1, /4, /16
  wire [3:0]  pre_last = (pre_sel == 2'b00) ? PT8_PRE_DIV1_END :
                         (pre_sel == 2'b01) ? PT8_PRE_DIV4_END : PT8_PRE_DIV16_END;
  wire        inc_tick;
  wire        post_pulse;

  pt8_scaler #(.W(4)) u_prescale (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (scl_clr),
    .tick    (instr_tick),
    .last    (pre_last),
    .pulse   (inc_tick)
  );

  wire        at_limit = (count_ff == limit_ff);
  wire        match    = inc_tick & at_limit;
  // a count above the limit runs on and wraps through 8'hFF back to zero
  assign nxt_count = wr_count ? pwdata[7:0] :
                     match    ? PT8_COUNT_RST :
                     inc_tick ? count_ff + 8'h01 : count_ff;

  pt8_scaler #(.W(4)) u_postscale (
    .pclk    (pclk),
    .presetn (presetn),
    .clr     (scl_clr),
    .tick    (match),
    .last    (post_sel),
    .pulse   (post_pulse)
  );

  // hardware set wins over a software clear in the same cycle
  assign nxt_flag = post_pulse | (wr_flags ? pwdata[PT8_MATCH_BIT] : flag_ff);

  wire [7:0] flags_rd = {6'b000000, flag_ff, 1'b0};
  wire [7:0] en_rd    = {6'b000000, irq_en_ff, 1'b0};
  assign nxt_rdata = (~psel | pwrite) ? 32'h0000_0000 :
                     hit_flags ? {24'h000000, flags_rd} :
                     hit_en    ? {24'h000000, en_rd} :
                     hit_count ? {24'h000000, count_ff} :
                     hit_ctrl  ? {25'h0000000, control_ff} :
                     hit_limit ? {24'h000000, limit_ff} : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qdiv_ff  <= 2'b00;
      count_ff <= PT8_COUNT_RST;
      flag_ff  <= PT8_FLAGS_RST[PT8_MATCH_BIT];
    end else begin
      qdiv_ff  <= nxt_qdiv;
      count_ff <= nxt_count;
      flag_ff  <= nxt_flag;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      limit_ff   <= PT8_LIMIT_RST;
      control_ff <= PT8_CONTROL_RST;
      irq_en_ff  <= PT8_ENABLES_RST[PT8_MATCH_BIT];
    end else begin
      if (wr & hit_limit) begin
        limit_ff <= pwdata[7:0];
      end
      if (wr_ctrl) begin
        control_ff <= pwdata[6:0];
      end
      if (wr & hit_en) begin
        irq_en_ff <= pwdata[PT8_MATCH_BIT];
      end
    end
  end

  // read data is registered in the setup cycle, so it is valid in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_ff  <= 32'h0000_0000;
      slverr_ff <= 1'b0;
      pwm_ff    <= 1'b0;
      ssp_ff    <= 1'b0;
      irq_ff    <= 1'b0;
      ready_ff  <= 1'b1;
    end else begin
      ready_ff  <= 1'b1;
      rdata_ff  <= nxt_rdata;
      slverr_ff <= psel & ~penable & ~mapped;
      pwm_ff    <= match;
      ssp_ff    <= match;
      irq_ff    <= nxt_flag & irq_en_ff;
    end
  end

  assign prdata           = rdata_ff;
  // no wait states; kept as a flop so every output leaves a register
  assign pready           = ready_ff;
  assign pslverr          = slverr_ff;
  assign pwm_period_match = pwm_ff;
  assign serial_shift_tick = ssp_ff;
  assign period_match_irq = irq_ff;
endmodule : pt8_timer

// [testbench/pt8_timer_chk.sv]
// port assertions for the period timer
`timescale 1ns/1ns
module pt8_timer_chk (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        pwm_period_match,
  input wire logic        serial_shift_tick,
  input wire logic        period_match_irq
);
  wire setup = psel && !penable;
  wire hit   = paddr inside {12'h030, 12'h044, 12'h048, 12'h230, 12'h248};
  wire wr    = psel && penable && pwrite;
  wire clr   = wr && (paddr == 12'h030 || paddr == 12'h230);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_high: assert property (pready) else $error("no ready");
  chk_tick_same: assert property (pwm_period_match == serial_shift_tick)
    else $error("match outputs differ");
  chk_match_single: assert property (pwm_period_match |=> !pwm_period_match)
    else $error("match pulse too long");
  chk_err_unmapped: assert property (setup && !hit |=> pslverr) else $error("no slverr");
  chk_err_mapped: assert property (setup && hit |=> !pslverr) else $error("bad slverr");
  chk_upper_zero: assert property (prdata[31:8] == 24'h0) else $error("upper bits set");
  chk_irq_off: assert property (wr && paddr == 12'h230 && !pwdata[1] |=> ##1
    !period_match_irq) else $error("request while disabled");
  chk_irq_hold: assert property ($fell(period_match_irq) |-> $past(clr) || $past(clr, 2))
    else $error("request dropped alone");
  cover property (pwm_period_match);
  cover property ($rose(period_match_irq));
  cover property (setup && !hit);
endmodule : pt8_timer_chk
bind pt8_timer pt8_timer_chk pt8_timer_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pwm_period_match(pwm_period_match),
  .serial_shift_tick(serial_shift_tick), .period_match_irq(period_match_irq));

// [testbench/test_pt8_timer.sv]
// self-checking bench for the period timer
`timescale 1ns/1ns
module test_pt8_timer;
  import pt8_pkg::*;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic        pready, pslverr, pwm, tick, irq, err;
  logic [15:0] seed = 16'hE1AE;
  logic [7:0]  ix[5] = '{PT8_FLAGS_IDX, PT8_ENABLES_IDX, PT8_COUNT_IDX, PT8_CONTROL_IDX,
                         PT8_LIMIT_IDX};
  logic [7:0]  rv[5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hFF};
  int          n_errors = 0, tests_run = 0, i, c, p, q, lim;
  always #5 pclk = ~pclk;
  pt8_timer pt8_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pwm_period_match(pwm), .serial_shift_tick(tick),
    .period_match_irq(irq));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    lfsr = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr
  task final_report;
    $display("checks %0d errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t: got %0h want %0h", $time, got, exp);
    end
  endtask : chk
  // one idle edge first, so a release and the next setup never share a time step
  task apb(input logic [7:0] idx, input logic w, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      chk(0, 1);
      final_report();
    end
    r = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task wait_match(output int n);
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (pwm !== 1'b1 && n < 3000);
  endtask : wait_match
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1;
    for (p = 0; p < 5; p++) begin
      apb(ix[p], 0, 0);
      chk(r, rv[p]);
    end
    apb(8'h13, 0, 0);
    chk({err, r[30:0]}, 32'h80000000);
    seed = lfsr(seed);
    apb(PT8_LIMIT_IDX, 1, seed[7:0]);
    apb(PT8_COUNT_IDX, 1, seed[15:8]);
    apb(PT8_CONTROL_IDX, 1, seed[7:0] & 8'hFB);
    apb(PT8_COUNT_IDX, 0, 0);
    chk(r, seed[15:8]);
    apb(PT8_CONTROL_IDX, 0, 0);
    chk(r, seed[7:0] & 8'h7B);
    apb(PT8_LIMIT_IDX, 0, 0);
    chk(r, seed[7:0]);
    $display("registers done");
    for (p = 0; p < 4; p++) begin
      seed = lfsr(seed);
      lim = seed[1:0];
      apb(PT8_CONTROL_IDX, 1, 0);
      apb(PT8_LIMIT_IDX, 1, lim[7:0]);
      apb(PT8_COUNT_IDX, 1, 0);
      apb(PT8_CONTROL_IDX, 1, {5'h01, p[1:0]});
      wait_match(c);
      wait_match(c);
      chk(tick, 1);
      chk(c, (lim + 1) * 4 * (p == 0 ? 1 : p == 1 ? 4 : 16));
    end
    $display("prescale done");
    q = seed[4:2];
    apb(PT8_CONTROL_IDX, 1, 0);
    apb(PT8_LIMIT_IDX, 1, 1);
    apb(PT8_COUNT_IDX, 1, 0);
    apb(PT8_ENABLES_IDX, 1, 2);
    apb(PT8_FLAGS_IDX, 1, 0);
    apb(PT8_CONTROL_IDX, 1, {1'b0, q[3:0], 3'b100});
    c = 0;
    for (i = 0; i < 400 && irq !== 1'b1; i++) begin
      @(negedge pclk);
      c += pwm;
    end
    chk(c, q + 1);
    apb(PT8_CONTROL_IDX, 1, 0);
    apb(PT8_COUNT_IDX, 0, 0);
    lim = r[7:0];
    repeat (40) @(negedge pclk);
    apb(PT8_COUNT_IDX, 0, 0);
    chk(r, lim);
    chk(irq, 1);
    apb(PT8_ENABLES_IDX, 1, 0);
    apb(PT8_FLAGS_IDX, 0, 0);
    chk({irq, r[30:0]}, 2);
    apb(PT8_FLAGS_IDX, 1, 0);
    apb(PT8_FLAGS_IDX, 0, 0);
    chk(r, 0);
    $display("postscale done");
    final_report();
  end
endmodule : test_pt8_timer
